// *** design/pfac_ctrl.sv ***
/*
  Quick-lock control for loop channel zero: AHB-Lite register slave,
  loop mode state machine, fast acquisition gating, done flag,
  automute and a level interrupt.
  Assumes pins arrive asynchronously and the bus runs on hclk.
*/
// The AHB-Lite slave port was decided locally.
module pfac_ctrl
  import pfac_pkg::*;
#(
  parameter int FAST_CYC = PFAC_FAST_CYC
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  input  wire pfac_pkg::pfac_pins_t pins,
  output pfac_pkg::pfac_loop_t   loop,
  output logic                   irq
);
  import pfac_pkg::*;

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  localparam int CW = $clog2(FAST_CYC + 1);

  pfac_pins_t  pins_s;
  pfac_state_t state_r;
  pfac_state_t state_nxt;
  logic [3:0]  mode_r;
  logic [3:0]  faq_r;
  logic [3:0]  faq_eff;
  logic [3:0]  ev_r;
  logic [3:0]  mask_r;
  logic [3:0]  ev_set;
  logic        done_r;
  logic        mute_r;
  logic        unmute_ok;
  logic        quick_ok;
  logic        quick_end;
  logic [CW-1:0] cnt_r;
  logic        wr_pend_r;
  logic [15:0] wr_idx_r;
  logic        wr_faq;
  logic        wr_clr;
  logic        wr_mode;
  logic        wr_irq;
  logic        wr_mask;
  logic        clr_done;
  logic        clr_mute;
  logic        rd_go;
  logic [7:0]  rd_val;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  pfac_sync #(
    .W ($bits(pfac_pins_t))
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pins),
    .q       (pins_s)
  );

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a,
                               input logic [15:0] idx);
    hit = (a[31:18] == 14'h0000) && (a[17:2] == idx);
  endfunction

  assign rd_go = hsel && hready && htrans == PFAC_HTRANS_NS && !hwrite;

  // address phase captured; data written in the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 16'h0000;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans == PFAC_HTRANS_NS && hwrite;
      wr_idx_r  <= haddr[17:2];
      if (haddr[31:18] != 14'h0000) begin
        wr_idx_r <= 16'h0000;
      end
    end
  end

  assign wr_mode = wr_pend_r && wr_idx_r == PFAC_MODE_IDX;
  assign wr_faq  = wr_pend_r && wr_idx_r == PFAC_FAQ_IDX;
  assign wr_clr  = wr_pend_r && wr_idx_r == PFAC_CLR_IDX;
  assign wr_irq  = wr_pend_r && wr_idx_r == PFAC_IRQ_IDX;
  assign wr_mask = wr_pend_r && wr_idx_r == PFAC_MASK_IDX;

  // strobes act for one cycle and are never stored
  assign clr_done = wr_clr && hwdata[PFAC_CLR_DONE_BIT];
  assign clr_mute = wr_clr && hwdata[PFAC_CLR_MUTE_BIT];

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= PFAC_MODE_RST;
    end else if (wr_mode) begin
      mode_r <= hwdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      faq_r <= PFAC_FAQ_RST;
    end else if (wr_faq) begin
      faq_r <= hwdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= PFAC_EV_RST;
    end else if (wr_mask) begin
      mask_r <= hwdata[3:0];
    end
  end

  // ------------------------------------------------------------------
  // quick-lock gating
  // ------------------------------------------------------------------
  assign faq_eff = (faq_r == 4'h0) ? PFAC_FAQ_ALL : faq_r;

  assign quick_ok =
      (!faq_eff[PFAC_FAQ_NOOUT_BIT] || !pins_s.out_sync)
   && (!faq_eff[PFAC_FAQ_FIRST_BIT] || !done_r);

  assign quick_end = state_r == PFAC_ST_QUICK
                  && cnt_r == CW'(FAST_CYC - 1);

  // ------------------------------------------------------------------
  // loop state machine
  // ------------------------------------------------------------------
  // freerun forcing outranks holdover forcing
  always_comb begin
    state_nxt = state_r;
    if (mode_r[PFAC_MODE_FREERUN_BIT]) begin
      state_nxt = PFAC_ST_FREE;
    end else if (mode_r[PFAC_MODE_HOLD_BIT]) begin
      state_nxt = PFAC_ST_HOLD;
    end else begin
      case (state_r)
        PFAC_ST_FREE: begin
          if (pins_s.ref_valid) begin
            if (faq_eff[PFAC_FAQ_FREE_BIT] && quick_ok) begin
              state_nxt = PFAC_ST_QUICK;
            end else begin
              state_nxt = PFAC_ST_TRACK;
            end
          end
        end
        PFAC_ST_HOLD: begin
          if (pins_s.ref_valid) begin
            if (faq_eff[PFAC_FAQ_HOLD_BIT] && quick_ok) begin
              state_nxt = PFAC_ST_QUICK;
            end else begin
              state_nxt = PFAC_ST_TRACK;
            end
          end
        end
        PFAC_ST_QUICK: begin
          if (!pins_s.ref_valid) begin
            state_nxt = PFAC_ST_HOLD;
          end else if (quick_end) begin
            state_nxt = PFAC_ST_TRACK;
          end
        end
        PFAC_ST_TRACK: begin
          if (!pins_s.ref_valid) begin
            state_nxt = PFAC_ST_HOLD;
          end
        end
        default: begin
          state_nxt = PFAC_ST_FREE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= PFAC_ST_FREE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // quick-lock duration counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
    end else if (state_r != PFAC_ST_QUICK) begin
      cnt_r <= '0;
    end else if (!quick_end) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // ------------------------------------------------------------------
  // done flag: completion wins over a clear in the same cycle
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_r <= 1'b0;
    end else if (quick_end && state_nxt == PFAC_ST_TRACK) begin
      done_r <= 1'b1;
    end else if (clr_done) begin
      done_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // automute
  // ------------------------------------------------------------------
  always_comb begin
    case (mode_r[PFAC_MODE_UNMUTE_LSB +: 2])
      PFAC_UNMUTE_NOW:   unmute_ok = 1'b1;
      PFAC_UNMUTE_TRACK: unmute_ok = state_r == PFAC_ST_TRACK;
      PFAC_UNMUTE_QUICK: unmute_ok = state_r == PFAC_ST_TRACK && done_r;
      default:           unmute_ok = 1'b0;
    endcase
  end

  // a clear restarts muting; the condition is then re-evaluated
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mute_r <= 1'b1;
    end else if (clr_mute) begin
      mute_r <= 1'b1;
    end else if (unmute_ok) begin
      mute_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // events and interrupt
  // ------------------------------------------------------------------
  assign ev_set[PFAC_EV_DONE]  = quick_end && state_nxt == PFAC_ST_TRACK;
  assign ev_set[PFAC_EV_TRACK] = state_nxt == PFAC_ST_TRACK
                              && state_r != PFAC_ST_TRACK;
  assign ev_set[PFAC_EV_HOLD]  = state_nxt == PFAC_ST_HOLD
                              && state_r != PFAC_ST_HOLD;
  assign ev_set[PFAC_EV_FREE]  = state_nxt == PFAC_ST_FREE
                              && state_r != PFAC_ST_FREE;

  // write one to clear; a new event in the same cycle stays set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_r <= PFAC_EV_RST;
    end else begin
      ev_r <= (ev_r & ~(wr_irq ? hwdata[3:0] : 4'h0)) | ev_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((ev_r & ~(wr_irq ? hwdata[3:0] : 4'h0)) | ev_set)
               & (wr_mask ? hwdata[3:0] : mask_r));
    end
  end

  // ------------------------------------------------------------------
  // loop outputs
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop <= '{loop_state: PFAC_ST_FREE, quick_active: 1'b0,
                use_history: 1'b0, mute: 1'b1};
    end else begin
      loop.loop_state   <= state_nxt;
      loop.quick_active <= state_nxt == PFAC_ST_QUICK;
      // history used only in holdover, and only when it exists
      loop.use_history  <= state_nxt == PFAC_ST_HOLD
                        && pins_s.hist_avail;
      loop.mute         <= clr_mute || (mute_r && !unmute_ok);
    end
  end

  // ------------------------------------------------------------------
  // read path: data registered at the address phase, zero wait
  // ------------------------------------------------------------------
  always_comb begin
    rd_val = 8'h00;
    if (hit(haddr, PFAC_MODE_IDX)) begin
      rd_val = {4'h0, mode_r};
    end else if (hit(haddr, PFAC_FAQ_IDX)) begin
      rd_val = {4'h0, faq_r};
    end else if (hit(haddr, PFAC_CLR_IDX)) begin
      rd_val = 8'h00;
    end else if (hit(haddr, PFAC_STAT_IDX)) begin
      rd_val = {state_r, 1'b0, loop.use_history, mute_r, done_r};
    end else if (hit(haddr, PFAC_IRQ_IDX)) begin
      rd_val = {4'h0, ev_r};
    end else if (hit(haddr, PFAC_MASK_IDX)) begin
      rd_val = {4'h0, mask_r};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata <= {24'h000000, rd_val};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule // pfac_ctrl

// *** design/pfac_pkg.sv ***
/*
  Package for the quick-lock control block: register indexes, field
  positions, reset values, loop states and the pin bundle.
  Assumes one clock (hclk) and one active-low asynchronous reset.
*/
package pfac_pkg;
  // ------------------------------------------------------------------
  // register indexes (byte address = index * 4)
  // ------------------------------------------------------------------
  localparam logic [15:0] PFAC_MODE_IDX = 16'h2105;
  localparam logic [15:0] PFAC_FAQ_IDX  = 16'h2106;
  localparam logic [15:0] PFAC_CLR_IDX  = 16'h2107;
  localparam logic [15:0] PFAC_STAT_IDX = 16'h2108;
  localparam logic [15:0] PFAC_IRQ_IDX  = 16'h2109;
  localparam logic [15:0] PFAC_MASK_IDX = 16'h210A;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PFAC_MODE_FREERUN_BIT = 0;
  localparam int PFAC_MODE_HOLD_BIT    = 1;
  localparam int PFAC_MODE_UNMUTE_LSB  = 2;
  localparam int PFAC_FAQ_NOOUT_BIT    = 3;
  localparam int PFAC_FAQ_FIRST_BIT    = 2;
  localparam int PFAC_FAQ_HOLD_BIT     = 1;
  localparam int PFAC_FAQ_FREE_BIT     = 0;
  localparam int PFAC_CLR_MUTE_BIT     = 4;
  localparam int PFAC_CLR_DONE_BIT     = 3;
  localparam int PFAC_EV_DONE          = 0;
  localparam int PFAC_EV_TRACK         = 1;
  localparam int PFAC_EV_HOLD          = 2;
  localparam int PFAC_EV_FREE          = 3;

  // ------------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------------
  localparam logic [3:0]  PFAC_MODE_RST  = 4'h0;
  localparam logic [3:0]  PFAC_FAQ_RST   = 4'h0;
  localparam logic [3:0]  PFAC_FAQ_ALL   = 4'hF;
  localparam logic [3:0]  PFAC_EV_RST    = 4'h0;
  localparam int          PFAC_FAST_CYC  = 64;
  localparam logic [1:0]  PFAC_HTRANS_NS = 2'h2;

  // auto-unmute conditions
  localparam logic [1:0] PFAC_UNMUTE_NOW   = 2'h0;
  localparam logic [1:0] PFAC_UNMUTE_TRACK = 2'h1;
  localparam logic [1:0] PFAC_UNMUTE_QUICK = 2'h2;

  typedef enum logic [3:0] {
    PFAC_ST_FREE  = 4'h1,
    PFAC_ST_QUICK = 4'h2,
    PFAC_ST_TRACK = 4'h4,
    PFAC_ST_HOLD  = 4'h8
  } pfac_state_t;

  typedef struct packed {
    logic ref_valid;
    logic out_sync;
    logic hist_avail;
  } pfac_pins_t;

  typedef struct packed {
    logic [3:0] loop_state;
    logic       quick_active;
    logic       use_history;
    logic       mute;
  } pfac_loop_t;
endpackage

// *** design/pfac_sync.sv ***
/*
  Two-flop level synchroniser, parameterised width.
  Assumes inputs are asynchronous levels; the first stage feeds
  only the second.
*/
module pfac_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // pfac_sync

// *** tb/pfac_ctrl_assertions.sv ***
/*
  Checker for pfac_ctrl: bus answer, read data width, loop state coding
  and quick lock timing. Assumes one clock and the bind below.
*/
module pfac_ctrl_checker
  import pfac_pkg::*;
#(
  parameter int FAST_CYC = PFAC_FAST_CYC
) (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [31:0]          hrdata,
  input wire pfac_pkg::pfac_pins_t pins,
  input wire pfac_pkg::pfac_loop_t loop
);
  timeunit 1ns;
  timeprecision 1ps;
  import pfac_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  int quick_cnt_r;
  // ------------------------------------------------
  // cycles spent in quick lock, zero outside it
  // ------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quick_cnt_r <= 0;
    end else if (loop.quick_active) begin
      quick_cnt_r <= quick_cnt_r + 1;
    end else begin
      quick_cnt_r <= 0;
    end
  end
  sequence s_ref_gone;
    !pins.ref_valid [*4];
  endsequence
  sequence s_quick_ends;
    $fell(loop.quick_active) ##0 (loop.loop_state == PFAC_ST_TRACK);
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_state_onehot: assert property ($onehot(loop.loop_state))
    else $error("loop state not one-hot");
  a_quick_flag: assert property (loop.quick_active == (loop.loop_state == PFAC_ST_QUICK))
    else $error("quick flag disagrees with state");
  a_quick_length: assert property (s_quick_ends |-> quick_cnt_r == FAST_CYC)
    else $error("quick lock length wrong");
  a_quick_entry: assert property ($rose(loop.quick_active) |->
    $past(loop.loop_state) inside {PFAC_ST_FREE, PFAC_ST_HOLD})
    else $error("quick lock entered from wrong state");
  a_ref_lost_hold: assert property ((loop.loop_state == PFAC_ST_TRACK) ##0 s_ref_gone
    |-> ##[1:3] (loop.loop_state inside {PFAC_ST_HOLD, PFAC_ST_FREE}))
    else $error("reference loss did not leave tracking");
  a_history_hold: assert property (loop.loop_state != PFAC_ST_HOLD |-> !loop.use_history)
    else $error("history used outside holdover");
endmodule // pfac_ctrl_checker

bind pfac_ctrl pfac_ctrl_checker #(.FAST_CYC(FAST_CYC)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins), .loop(loop));

// *** tb/pfac_ctrl_tb.sv ***
/*
  Bench for pfac_ctrl: register table loop, then loop mode scenarios.
  Assumes the checker is bound by its own file; quick lock shortened to 4.
*/
module pfac_ctrl_tb
  import pfac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  import pfac_pkg::*;
  typedef struct packed {
    logic [15:0] idx;
    logic [31:0] wd;
    logic [31:0] ex;
  } pfac_row_t;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  int          quick_cyc = 0;
  int          mute_cyc = 0;
  int          base;
  pfac_pins_t  pins = '0;
  pfac_loop_t  loop;
  int          failures = 0;
  int          num_checks = 0;
  pfac_row_t   rows [9] = '{'{PFAC_FAQ_IDX, 32'hFF, 32'hF}, '{PFAC_FAQ_IDX, 32'hA5, 32'h5},
    '{PFAC_CLR_IDX, 32'hFF, 32'h0}, '{PFAC_MASK_IDX, 32'hF, 32'hF}, '{16'h2100, 32'hFF, 32'h0},
    '{PFAC_MODE_IDX, 32'hC, 32'hC}, '{PFAC_FAQ_IDX, 32'h0, 32'h0},
    '{PFAC_MODE_IDX, 32'h0, 32'h0}, '{PFAC_MASK_IDX, 32'h1, 32'h1}};

  always #4 hclk = ~hclk;
  always @(posedge hclk) begin
    if (loop.quick_active === 1'b1) quick_cyc <= quick_cyc + 1;
    if (loop.mute === 1'b1) mute_cyc <= mute_cyc + 1;
  end

  pfac_ctrl #(.FAST_CYC(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins), .loop(loop), .irq(irq));

  // ------------------------------------------------
  // compare tasks and bus cycles
  // ------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] ex);
    num_checks++;
    if (got !== ex) begin
      failures++;
      $display("mismatch at %0t: register %h expected %h", $time, got, ex);
    end
  endtask
  task automatic chk_sig(input logic got, input logic ex);
    num_checks++;
    if (got !== ex) begin
      failures++;
      $display("mismatch at %0t: signal %b expected %b", $time, got, ex);
    end
  endtask
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'b00};
    htrans <= PFAC_HTRANS_NS;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] ex);
    xfer(1'b0, idx, 32'h0);
    chk_reg(rd, ex);
  endtask
  task automatic wait_st(input logic [3:0] s);
    int n;
    n = 0;
    while (loop.loop_state !== s && n < 40) begin
      @(posedge hclk);
      n++;
    end
    chk_reg({28'h0, loop.loop_state}, {28'h0, s});
  endtask
  // force freerun, release, and see whether quick lock ran on the way to tracking
  task automatic relock(input logic exp_q);
    int q0;
    wr(PFAC_MODE_IDX, 32'h1);
    wait_st(PFAC_ST_FREE);
    q0 = quick_cyc;
    wr(PFAC_MODE_IDX, 32'h0);
    wait_st(PFAC_ST_TRACK);
    chk_sig(quick_cyc != q0, exp_q);
  endtask
  task automatic wrap_up;
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // sized well above the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wait_st(PFAC_ST_FREE);
    chk_sig(loop.mute, 1'b1);
    chk_sig(irq, 1'b0);
    rdc(PFAC_FAQ_IDX, 32'h0);
    rdc(PFAC_CLR_IDX, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].ex);
    end
    pins.ref_valid <= 1'b1;
    wait_st(PFAC_ST_TRACK);
    chk_sig(quick_cyc != 0, 1'b1);
    rdc(PFAC_STAT_IDX, 32'h41);
    repeat (3) @(posedge hclk);
    chk_sig(irq, 1'b1);
    wr(PFAC_MASK_IDX, 32'h0);
    repeat (3) @(posedge hclk);
    chk_sig(irq, 1'b0);
    wr(PFAC_MASK_IDX, 32'h1);
    wr(PFAC_IRQ_IDX, 32'hF);
    repeat (3) @(posedge hclk);
    chk_sig(irq, 1'b0);
    rdc(PFAC_IRQ_IDX, 32'h0);
    wr(PFAC_FAQ_IDX, 32'h5);
    relock(1'b0);
    rdc(PFAC_IRQ_IDX, 32'hA);
    wr(PFAC_CLR_IDX, 32'h8);
    rdc(PFAC_STAT_IDX, 32'h40);
    relock(1'b1);
    wr(PFAC_FAQ_IDX, 32'h2);
    relock(1'b0);
    pins.hist_avail <= 1'b1;
    wr(PFAC_MODE_IDX, 32'h2);
    wait_st(PFAC_ST_HOLD);
    chk_sig(loop.use_history, 1'b1);
    base = quick_cyc;
    wr(PFAC_MODE_IDX, 32'h0);
    wait_st(PFAC_ST_TRACK);
    chk_sig(quick_cyc != base, 1'b1);
    wr(PFAC_FAQ_IDX, 32'h9);
    pins.out_sync <= 1'b1;
    relock(1'b0);
    pins.out_sync <= 1'b0;
    relock(1'b1);
    wr(PFAC_MODE_IDX, 32'h4);
    repeat (3) @(posedge hclk);
    base = mute_cyc;
    wr(PFAC_CLR_IDX, 32'h10);
    repeat (3) @(posedge hclk);
    chk_sig(mute_cyc != base, 1'b1);
    chk_sig(loop.mute, 1'b0);
    // unmute needs tracking and the done flag; clearing both keeps it muted
    wr(PFAC_MODE_IDX, 32'h8);
    wr(PFAC_CLR_IDX, 32'h18);
    repeat (3) @(posedge hclk);
    chk_sig(loop.mute, 1'b1);
    pins.ref_valid <= 1'b0;
    wait_st(PFAC_ST_HOLD);
    chk_sig(loop.use_history, 1'b1);
    // reset in mid-run: outputs and registers back to reset values
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk_reg({28'h0, loop.loop_state}, {28'h0, PFAC_ST_FREE});
    chk_sig(loop.mute, 1'b1);
    chk_sig(loop.use_history, 1'b0);
    chk_sig(irq, 1'b0);
    hresetn <= 1'b1;
    rdc(PFAC_FAQ_IDX, 32'h0);
    rdc(PFAC_MASK_IDX, 32'h0);
    wrap_up();
  end
endmodule // pfac_ctrl_tb
